// ==== rtl/ssl_regs.svh ====
/*
  Named constants of the stack and subroutine linkage engine.
  Assumes inclusion by bare name from the rtl folder.
*/
`ifndef SSL_REGS_SVH
`define SSL_REGS_SVH

// Pointer steps for word and byte stack items.
`define SSL_WORD_STEP 16'h0002
`define SSL_BYTE_STEP 16'h0001
// Register indices with a fixed role.
`define SSL_SP_INDEX  3'h6
`define SSL_PC_INDEX  3'h7
// Reset value of every general register.
`define SSL_RESET_WORD 16'h0000
// Mask that keeps the hardware stack pointer even.
`define SSL_EVEN_MASK 16'hfffe
// Mask of the low byte of a memory word.
`define SSL_BYTE_MASK 16'h00ff

`endif

// ==== rtl/ssl_pkg.sv ====
/*
  Types of the stack and subroutine linkage engine.
  Assumes ssl_regs.svh for numeric constants.
*/
package ssl_pkg;

  typedef enum logic [2:0] {
    SSL_OP_LOAD = 3'b000,
    SSL_OP_PUSH = 3'b001,
    SSL_OP_POP  = 3'b010,
    SSL_OP_JSR  = 3'b011,
    SSL_OP_RTS  = 3'b100,
    SSL_OP_INTR = 3'b101
  } ssl_op_type;

  typedef enum logic [1:0] {
    SSL_IDLE  = 2'b00,
    SSL_WRITE = 2'b01,
    SSL_READ  = 2'b10
  } ssl_state_type;

  typedef struct packed {
    ssl_op_type  op;
    logic [2:0]  sel;
    logic        byte_op;
    logic [15:0] data;
    logic [15:0] target;
  } ssl_cmd_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        byte_en;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ssl_mem_type;

  typedef struct packed {
    ssl_state_type    state;
    ssl_op_type       op;
    logic [2:0]       sel;
    logic             second;
    logic [15:0]      target;
    logic [7:0][15:0] regs;
    logic [15:0]      addr;
    logic [15:0]      wdata;
    logic             we;
    logic             byte_op;
    logic             done;
    logic             err;
    logic [15:0]      result;
  } ssl_core_type;

endpackage

// ==== rtl/ssl_step.sv ====
/*
  Pointer stepper for autodecrement and autoincrement.
  Assumes the caller says whether the pointer is the hardware stack pointer.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssl_regs.svh"

module ssl_step #(
  parameter int WIDTH = 16
) (
  // Pointer in.
  input  wire logic [WIDTH-1:0] ptr,
  input  wire logic             is_sp,
  input  wire logic             byte_op,
  input  wire logic             dec,
  // Pointer out.
  output logic      [WIDTH-1:0] stepped
);

  logic [WIDTH-1:0] amount;

  generate
    if (WIDTH != 16) begin : g_bad_width
      $error("ssl_step serves only a 16-bit pointer");
    end
  endgenerate

  always_comb begin
    // The hardware stack pointer never takes a byte step.
    amount = (byte_op && !is_sp) ? `SSL_BYTE_STEP : `SSL_WORD_STEP;
    // Pushes go downward, pops upward.
    stepped = dec ? ptr - amount : ptr + amount;
  end

endmodule
`default_nettype wire

// ==== rtl/ssl_stack_linkage.sv ====
/*
  Stack and subroutine linkage engine: eight general registers, push and
  pop through any register but seven, subroutine jump and return, interrupt entry.
  Assumes one-clock memory on the same clock that holds ack high for one
  cycle per accepted request, and a sequencer that issues commands.
*/
// Operation
// - Stacks start at their top address and grow toward lower addresses.
// - Linkage and interrupt entry always use register six as stack pointer.
// - Register seven is the program counter and is refused as stack pointer.
// - Stacks on registers other than six may be byte or word stacks.
// - Loads and steps keep register six even, and it steps only by words.
// - Push decrements the pointer first, then writes at the new address.
// - Pop reads at the pointer, then increments the pointer.
// - The pointer always addresses the most recently stored item.
// - Subroutine jump first pushes the linkage register on the hardware stack.
// - Then the linkage register gets the return address and control jumps.
// - Return copies the register to the counter, then pops the register.
// - Interrupt pushes the status word, then the program counter.
`timescale 1ns/1ns
`default_nettype none
`include "ssl_regs.svh"

module ssl_stack_linkage (
  // Clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Command port.
  input  wire logic                cmd_valid,
  input  wire ssl_pkg::ssl_cmd_type cmd,
  output logic                     cmd_ready,
  // Memory port.
  output ssl_pkg::ssl_mem_type     mem,
  input  wire logic                mem_ack,
  input  wire logic [15:0]         mem_rdata,
  // Status.
  output logic                     done,
  output logic                     err,
  output logic [15:0]              result,
  output logic [15:0]              pc,
  output logic [15:0]              sp
);

  ssl_pkg::ssl_core_type core;
  ssl_pkg::ssl_core_type next_core;
  logic                  accept;
  logic [2:0]            ptr_idx;
  logic                  step_byte;
  logic                  step_dec;
  logic [15:0]           stepped;

  function automatic logic uses_hw_stack(input ssl_pkg::ssl_op_type op);
    uses_hw_stack = (op != ssl_pkg::SSL_OP_PUSH) && (op != ssl_pkg::SSL_OP_POP);
  endfunction

  assign accept    = cmd_valid && (core.state == ssl_pkg::SSL_IDLE);
  assign cmd_ready = core.state == ssl_pkg::SSL_IDLE;

  always_comb begin
    if (core.state == ssl_pkg::SSL_IDLE) begin
      // Linkage and interrupt entry never select their pointer.
      ptr_idx   = uses_hw_stack(cmd.op) ? `SSL_SP_INDEX : cmd.sel;
      step_byte = cmd.byte_op && !uses_hw_stack(cmd.op);
      step_dec  = cmd.op != ssl_pkg::SSL_OP_POP;
    end else if (core.state == ssl_pkg::SSL_WRITE) begin
      ptr_idx   = `SSL_SP_INDEX;
      step_byte = 1'b0;
      step_dec  = 1'b1;
    end else begin
      ptr_idx   = (core.op == ssl_pkg::SSL_OP_POP) ? core.sel : `SSL_SP_INDEX;
      step_byte = core.byte_op;
      step_dec  = 1'b0;
    end
  end

  ssl_step #(
    .WIDTH   (16)
  ) u_step (
    .ptr     (core.regs[ptr_idx]),
    .is_sp   (ptr_idx == `SSL_SP_INDEX),
    .byte_op (step_byte),
    .dec     (step_dec),
    .stepped (stepped)
  );

  always_comb begin
    next_core      = core;
    next_core.done = 1'b0;
    next_core.err  = 1'b0;
    case (core.state)
      ssl_pkg::SSL_IDLE: begin
        if (accept) begin
          next_core.op      = cmd.op;
          next_core.sel     = cmd.sel;
          next_core.target  = cmd.target;
          next_core.second  = 1'b0;
          // Byte items are allowed on any pointer but register six.
          next_core.byte_op = cmd.byte_op && (cmd.sel != `SSL_SP_INDEX);
          case (cmd.op)
            ssl_pkg::SSL_OP_LOAD: begin
              next_core.regs[cmd.sel] = cmd.data;
              if (cmd.sel == `SSL_SP_INDEX) begin
                // A load never puts an odd address into register six.
                next_core.regs[cmd.sel] = cmd.data & `SSL_EVEN_MASK;
              end
              next_core.done = 1'b1;
            end
            ssl_pkg::SSL_OP_PUSH: begin
              if (cmd.sel == `SSL_PC_INDEX) begin
                // The program counter is no stack pointer.
                next_core.err  = 1'b1;
                next_core.done = 1'b1;
              end else begin
                // Decrement first, then write at the new top.
                next_core.regs[cmd.sel] = stepped;
                next_core.addr          = stepped;
                next_core.wdata         = cmd.data;
                next_core.we            = 1'b1;
                next_core.state         = ssl_pkg::SSL_WRITE;
              end
            end
            ssl_pkg::SSL_OP_POP: begin
              if (cmd.sel == `SSL_PC_INDEX) begin
                next_core.err  = 1'b1;
                next_core.done = 1'b1;
              end else begin
                // Read at the pointer; increment comes with the data.
                next_core.addr  = core.regs[cmd.sel];
                next_core.we    = 1'b0;
                next_core.state = ssl_pkg::SSL_READ;
              end
            end
            ssl_pkg::SSL_OP_JSR: begin
              // Save the linkage register as a word push on register six.
              next_core.regs[`SSL_SP_INDEX] = stepped;
              next_core.addr                = stepped;
              next_core.wdata               = core.regs[cmd.sel];
              next_core.we                  = 1'b1;
              next_core.byte_op             = 1'b0;
              next_core.state               = ssl_pkg::SSL_WRITE;
            end
            ssl_pkg::SSL_OP_RTS: begin
              // Counter first, then the register is popped.
              next_core.regs[`SSL_PC_INDEX] = core.regs[cmd.sel];
              next_core.addr                = core.regs[`SSL_SP_INDEX];
              next_core.we                  = 1'b0;
              next_core.byte_op             = 1'b0;
              next_core.state               = ssl_pkg::SSL_READ;
            end
            ssl_pkg::SSL_OP_INTR: begin
              // Status word goes first, the counter follows.
              next_core.regs[`SSL_SP_INDEX] = stepped;
              next_core.addr                = stepped;
              next_core.wdata               = cmd.data;
              next_core.we                  = 1'b1;
              next_core.byte_op             = 1'b0;
              next_core.second              = 1'b1;
              next_core.state               = ssl_pkg::SSL_WRITE;
            end
            default: begin
              next_core.err  = 1'b1;
              next_core.done = 1'b1;
            end
          endcase
        end
      end
      ssl_pkg::SSL_WRITE: begin
        if (mem_ack) begin
          if (core.second) begin
            // The counter is pushed before it is replaced.
            next_core.regs[`SSL_SP_INDEX] = stepped;
            next_core.addr                = stepped;
            next_core.wdata               = core.regs[`SSL_PC_INDEX];
            next_core.second              = 1'b0;
          end else begin
            if (core.op == ssl_pkg::SSL_OP_JSR) begin
              // Return address into the link, then jump to the entry.
              next_core.regs[core.sel]      = core.regs[`SSL_PC_INDEX];
              next_core.regs[`SSL_PC_INDEX] = core.target;
            end else if (core.op == ssl_pkg::SSL_OP_INTR) begin
              next_core.regs[`SSL_PC_INDEX] = core.target;
            end
            next_core.we    = 1'b0;
            next_core.done  = 1'b1;
            next_core.state = ssl_pkg::SSL_IDLE;
          end
        end
      end
      ssl_pkg::SSL_READ: begin
        if (mem_ack) begin
          next_core.result = core.byte_op ? (mem_rdata & `SSL_BYTE_MASK) : mem_rdata;
          if (core.op == ssl_pkg::SSL_OP_RTS) begin
            next_core.regs[core.sel]      = mem_rdata;
            next_core.regs[`SSL_SP_INDEX] = stepped;
          end else begin
            // The popped slot becomes free above the new top.
            next_core.regs[core.sel] = stepped;
          end
          next_core.done  = 1'b1;
          next_core.state = ssl_pkg::SSL_IDLE;
        end
      end
      default: begin
        next_core.state = ssl_pkg::SSL_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core <= '0;
    end else begin
      core <= next_core;
    end
  end

  // Request is a handshake output and follows the state directly.
  assign mem.req     = core.state != ssl_pkg::SSL_IDLE;
  assign mem.we      = core.we;
  assign mem.byte_en = core.byte_op;
  assign mem.addr    = core.addr;
  assign mem.wdata   = core.wdata;
  assign done        = core.done;
  assign err         = core.err;
  assign result      = core.result;
  assign pc          = core.regs[`SSL_PC_INDEX];
  assign sp          = core.regs[`SSL_SP_INDEX];

  property p_sp_even;
    @(posedge sys_clk) disable iff (rst) sp[0] == 1'b0;
  endproperty
  a_sp_even: assert property (p_sp_even) else $error("odd hardware stack pointer");

  property p_push_dec;
    @(posedge sys_clk) disable iff (rst)
      accept && cmd.op == ssl_pkg::SSL_OP_PUSH && cmd.sel != `SSL_PC_INDEX && !cmd.byte_op
      |=> mem.addr == $past(core.regs[cmd.sel]) - `SSL_WORD_STEP && mem.we && mem.req;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push did not predecrement");

  property p_pop_inc;
    @(posedge sys_clk) disable iff (rst)
      core.state == ssl_pkg::SSL_READ && core.op == ssl_pkg::SSL_OP_POP && mem_ack
      |=> core.regs[$past(core.sel)] == $past(mem.addr)
          + ($past(core.byte_op) ? `SSL_BYTE_STEP : `SSL_WORD_STEP) && done;
  endproperty
  a_pop_inc: assert property (p_pop_inc) else $error("pop did not postincrement");

  property p_pc_refused;
    @(posedge sys_clk) disable iff (rst)
      accept && cmd.sel == `SSL_PC_INDEX
      && (cmd.op == ssl_pkg::SSL_OP_PUSH || cmd.op == ssl_pkg::SSL_OP_POP)
      |=> err && done && !mem.req;
  endproperty
  a_pc_refused: assert property (p_pc_refused) else $error("counter used as pointer");

  property p_jsr_save;
    @(posedge sys_clk) disable iff (rst)
      accept && cmd.op == ssl_pkg::SSL_OP_JSR
      |=> sp == $past(sp) - `SSL_WORD_STEP && mem.wdata == $past(core.regs[cmd.sel])
          && mem.addr == sp && !mem.byte_en;
  endproperty
  a_jsr_save: assert property (p_jsr_save) else $error("linkage not saved");

  property p_jsr_link;
    @(posedge sys_clk) disable iff (rst)
      core.state == ssl_pkg::SSL_WRITE && core.op == ssl_pkg::SSL_OP_JSR && mem_ack
      |=> pc == $past(core.target) && cmd_ready;
  endproperty
  a_jsr_link: assert property (p_jsr_link) else $error("jump did not reach entry");

  property p_rts;
    @(posedge sys_clk) disable iff (rst)
      accept && cmd.op == ssl_pkg::SSL_OP_RTS
      |=> pc == $past(core.regs[cmd.sel]) && mem.addr == $past(sp) && !mem.we;
  endproperty
  a_rts: assert property (p_rts) else $error("return order wrong");

  property p_intr_order;
    @(posedge sys_clk) disable iff (rst)
      core.state == ssl_pkg::SSL_WRITE && core.second && mem_ack
      |=> mem.req && mem.we && mem.wdata == $past(pc) && sp == $past(sp) - `SSL_WORD_STEP;
  endproperty
  a_intr_order: assert property (p_intr_order) else $error("counter not pushed second");

  property p_top;
    @(posedge sys_clk) disable iff (rst)
      mem.req && mem.we && core.op != ssl_pkg::SSL_OP_PUSH |-> mem.addr == sp;
  endproperty
  a_top: assert property (p_top) else $error("write not at stack top");

  property p_intr_first;
    @(posedge sys_clk) disable iff (rst)
      accept && cmd.op == ssl_pkg::SSL_OP_INTR
      |=> mem.wdata == $past(cmd.data) && sp == $past(sp) - `SSL_WORD_STEP;
  endproperty
  a_intr_first: assert property (p_intr_first) else $error("status not pushed first");

  property p_sp_word;
    @(posedge sys_clk) disable iff (rst)
      accept && cmd.op == ssl_pkg::SSL_OP_PUSH && cmd.sel == `SSL_SP_INDEX
      |=> !mem.byte_en && sp == $past(sp) - `SSL_WORD_STEP;
  endproperty
  a_sp_word: assert property (p_sp_word) else $error("byte step on register six");

endmodule
`default_nettype wire

// ==== tb/ssl_mem_model.sv ====
/*
  Behavioural main memory for the stack and subroutine linkage engine.
  Assumes one request at a time on the same clock, held until acknowledged.
*/
`timescale 1ns/1ns
`default_nettype none

module ssl_mem_model (
  // Clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Memory port.
  input  wire ssl_pkg::ssl_mem_type mem,
  output logic                      mem_ack,
  output logic [15:0]               mem_rdata,
  // Wait cycles before each answer.
  input  wire logic [7:0]           lat
);
  logic [7:0]  ram [0:65535];
  logic [7:0]  wait_cnt;
  logic [15:0] last_addr;
  logic        last_be;
  int          n_access;

  // A known fill so that a byte read returns a nonzero upper byte.
  initial begin
    for (int i = 0; i < 65536; i++) begin
      ram[i] = 8'h5a ^ i[7:0];
    end
  end

  function automatic logic [15:0] peek(input logic [15:0] a);
    return {ram[a + 16'h0001], ram[a]};
  endfunction

  // Read data is inverted every idle cycle, so a stale value never looks valid.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_cnt  <= 8'h00;
      n_access  <= 0;
    end else if (mem.req && !mem_ack && wait_cnt != lat) begin
      wait_cnt  <= wait_cnt + 8'h01;
      mem_rdata <= ~mem_rdata;
    end else if (mem.req && !mem_ack) begin
      mem_ack   <= 1'b1;
      wait_cnt  <= 8'h00;
      last_addr <= mem.addr;
      last_be   <= mem.byte_en;
      n_access  <= n_access + 1;
      if (mem.we) begin
        ram[mem.addr] <= mem.wdata[7:0];
        if (!mem.byte_en) begin
          ram[mem.addr + 16'h0001] <= mem.wdata[15:8];
        end
      end else begin
        mem_rdata <= {ram[mem.addr + 16'h0001], ram[mem.addr]};
      end
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

`default_nettype wire

// ==== tb/ssl_stack_linkage_bench.sv ====
/*
  Self-checking bench of the stack and subroutine linkage engine.
  Assumes the memory model of this folder on the far side.
*/
`timescale 1ns/1ns
`default_nettype none

module ssl_stack_linkage_bench;
  localparam logic [2:0] LD = ssl_pkg::SSL_OP_LOAD;
  localparam logic [2:0] PU = ssl_pkg::SSL_OP_PUSH;
  localparam logic [2:0] PO = ssl_pkg::SSL_OP_POP;
  localparam logic [2:0] JS = ssl_pkg::SSL_OP_JSR;
  localparam logic [2:0] RT = ssl_pkg::SSL_OP_RTS;
  localparam logic [2:0] IN = ssl_pkg::SSL_OP_INTR;
  logic                 sys_clk;
  logic                 rst;
  logic                 cmd_valid;
  ssl_pkg::ssl_cmd_type cmd;
  logic                 cmd_ready;
  ssl_pkg::ssl_mem_type mem;
  logic                 mem_ack;
  logic [15:0]          mem_rdata;
  logic                 done;
  logic                 err;
  logic [15:0]          result;
  logic [15:0]          pc;
  logic [15:0]          sp;
  logic [7:0]           lat;
  logic                 last_err;
  int                   n_errors;
  int                   n_compared;
  int                   n_cycles;
  int                   n_before;

  ssl_stack_linkage dut_u (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .done(done),
    .err(err), .result(result), .pc(pc), .sp(sp));
  ssl_mem_model mem_u (.sys_clk(sys_clk), .rst(rst), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .lat(lat));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hung handshake must not stall the run forever.
  always @(posedge sys_clk) begin
    n_cycles++;
    if (n_cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Offers one command, then waits a bounded time for its done pulse.
  task automatic run(input logic [2:0] op, input logic [2:0] sel, input logic bo,
                     input logic [15:0] data, input logic [15:0] tgt);
    int i;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd       <= {op, sel, bo, data, tgt};
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 200; i++) begin
      @(negedge sys_clk);
      if (done === 1'b1) break;
    end
    check(16'(i < 200), 16'h0001);
    last_err = err;
  endtask

  task automatic t_reset();
    check(pc, 16'h0000);
    check(sp, 16'h0000);
    check(result, 16'h0000);
    check({15'h0000, cmd_ready, mem.req}, 16'h0002);
    $display("test reset done");
  endtask

  task automatic t_word_stack();
    run(LD, 3'h3, 1'b0, 16'h0100, 16'h0000);
    run(PU, 3'h3, 1'b0, 16'ha5a5, 16'h0000);
    check(mem_u.last_addr, 16'h00fe);
    check(last_err, 16'h0000);
    run(PU, 3'h3, 1'b0, 16'h5a5a, 16'h0000);
    check(mem_u.peek(16'h00fc), 16'h5a5a);
    check(mem_u.peek(16'h00fe), 16'ha5a5);
    lat <= 8'h02;
    run(PO, 3'h3, 1'b0, 16'h0000, 16'h0000);
    check(result, 16'h5a5a);
    run(PO, 3'h3, 1'b0, 16'h0000, 16'h0000);
    check(result, 16'ha5a5);
    run(PU, 3'h3, 1'b0, 16'h0001, 16'h0000);
    check(mem_u.last_addr, 16'h00fe);
    lat <= 8'h00;
    $display("test word_stack done");
  endtask

  task automatic t_byte_stack();
    run(LD, 3'h2, 1'b0, 16'h0041, 16'h0000);
    run(PU, 3'h2, 1'b1, 16'h0011, 16'h0000);
    check({mem_u.last_be, mem_u.last_addr[14:0]}, 16'h8040);
    run(PU, 3'h2, 1'b1, 16'h0022, 16'h0000);
    check(mem_u.last_addr, 16'h003f);
    check({8'h00, mem_u.ram[16'h003f]}, 16'h0022);
    run(PO, 3'h2, 1'b1, 16'h0000, 16'h0000);
    check(result, 16'h0022);
    run(PO, 3'h2, 1'b1, 16'h0000, 16'h0000);
    check(result, 16'h0011);
    run(PU, 3'h2, 1'b1, 16'h0033, 16'h0000);
    check(mem_u.last_addr, 16'h0040);
    $display("test byte_stack done");
  endtask

  task automatic t_hw_stack();
    run(LD, 3'h6, 1'b0, 16'h0201, 16'h0000);
    check(sp, 16'h0200);
    run(PU, 3'h6, 1'b1, 16'h1234, 16'h0000);
    check(sp, 16'h01fe);
    check({15'h0000, mem_u.last_be}, 16'h0000);
    check(mem_u.peek(16'h01fe), 16'h1234);
    run(PO, 3'h6, 1'b1, 16'h0000, 16'h0000);
    check(sp, 16'h0200);
    check(result, 16'h1234);
    $display("test hw_stack done");
  endtask

  task automatic t_refuse();
    run(LD, 3'h7, 1'b0, 16'h0500, 16'h0000);
    n_before = mem_u.n_access;
    run(PU, 3'h7, 1'b0, 16'h7777, 16'h0000);
    check(last_err, 16'h0001);
    run(PO, 3'h7, 1'b0, 16'h0000, 16'h0000);
    check(last_err, 16'h0001);
    check(16'(mem_u.n_access - n_before), 16'h0000);
    check(pc, 16'h0500);
    run(3'h6, 3'h1, 1'b0, 16'h0000, 16'h0000);
    check(last_err, 16'h0001);
    run(3'h7, 3'h1, 1'b0, 16'h0000, 16'h0000);
    check(last_err, 16'h0001);
    $display("test refuse done");
  endtask

  // A reset in the middle of a push must abandon it and clear the counter and the stack pointer.
  task automatic t_mid_reset();
    run(LD, 3'h7, 1'b0, pc + 16'h0002, 16'h0000);
    check(pc, 16'h0502);
    lat <= 8'h08;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd       <= {PU, 3'h1, 1'b0, 16'h4321, 16'h0000};
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    @(posedge sys_clk);
    rst <= 1'b1;
    lat <= 8'h00;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check(pc, 16'h0000);
    check(sp, 16'h0000);
    check({15'h0000, cmd_ready, mem.req}, 16'h0002);
    check(16'(mem_u.n_access), 16'h0000);
    $display("test mid_reset done");
  endtask

  task automatic t_linkage();
    run(LD, 3'h7, 1'b0, 16'h1002, 16'h0000);
    run(LD, 3'h5, 1'b0, 16'h1234, 16'h0000);
    run(LD, 3'h6, 1'b0, 16'h0300, 16'h0000);
    lat <= 8'h03;
    run(JS, 3'h5, 1'b1, 16'h0000, 16'h2000);
    check(sp, 16'h02fe);
    check(mem_u.peek(16'h02fe), 16'h1234);
    check(pc, 16'h2000);
    run(RT, 3'h5, 1'b1, 16'h0000, 16'h0000);
    check(pc, 16'h1002);
    check(sp, 16'h0300);
    run(RT, 3'h5, 1'b0, 16'h0000, 16'h0000);
    check(pc, 16'h1234);
    lat <= 8'h00;
    run(LD, 3'h7, 1'b0, 16'h2000, 16'h0000);
    run(LD, 3'h6, 1'b0, 16'h0400, 16'h0000);
    run(IN, 3'h4, 1'b1, 16'h00e0, 16'h3000);
    check(mem_u.peek(16'h03fe), 16'h00e0);
    check(mem_u.peek(16'h03fc), 16'h2000);
    check(sp, 16'h03fc);
    check(pc, 16'h3000);
    $display("test linkage done");
  endtask

  initial begin
    rst        = 1'b1;
    cmd_valid  = 1'b0;
    cmd        = '0;
    lat        = 8'h00;
    n_errors   = 0;
    n_compared = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    t_reset();
    t_word_stack();
    t_byte_stack();
    t_hw_stack();
    t_refuse();
    t_mid_reset();
    t_linkage();
    test_done();
  end
endmodule

`default_nettype wire
